/* File: logic/sar_adc_pkg.sv */
// constants for the sar adc conversion and serial readout block
//
// What this block does
// [RQ1] a conversion-start rising edge while idle begins sampling and conversion; every rising edge latches the mode
// [RQ2] serial input low at that edge selects daisy-chain, high selects chip-select
// [RQ3] chip-select mode drives output while serial input or conversion-start is low
// [RQ4] chip-select mode arms busy bit if either input is low at conversion end
// [RQ5] serial output changes only at conversion end and on serial clock falling edges
// [RQ6] output shift register advances only while the device is selected
// [RQ7] daisy-chain mode shifts serial input bits in behind the own result
// [RQ8] each result is an 18-bit word from an internal conversion clock
// [RQ9] host leaves at least 500 ns acquisition between conversion end and next start
// [RQ10] host starts conversions at no less than 10 Hz
// [RQ11] host starts conversions no faster than 500 ksps
// [RQ12] armed busy bit marks conversion end and one extra clock flushes it
// [RQ13] daisy-chain busy bit enabled when serial clock is high at start edge
// [RQ14] result is offset binary, midscale 20000 hex
// [RQ15] result goes out msb first, output released when not enabled
`default_nettype none

package sar_adc_pkg;
   // -----------------------------------------------------------------
   // widths and codes
   // -----------------------------------------------------------------
   localparam int               RESULT_WIDTH = 18;
   localparam logic [17:0]      MIDSCALE_CODE = 18'h20000;
   localparam logic [17:0]      RESULT_RESET  = 18'h00000;

   // -----------------------------------------------------------------
   // timing, clock is 10 MHz
   // -----------------------------------------------------------------
   localparam int               CLOCK_PERIOD_NS  = 100;
   localparam int               CONV_TIME_NS     = 1500;
   localparam int               CONV_CYCLES      = CONV_TIME_NS / CLOCK_PERIOD_NS;
   localparam int               ACQ_TIME_NS      = 500;
   localparam int               ACQ_CYCLES       = (ACQ_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [4:0]       CONV_COUNT       = 5'(CONV_CYCLES);

   // -----------------------------------------------------------------
   // conversion states, one-hot
   // -----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      IDLE_STATE    = 2'b01,
      CONVERT_STATE = 2'b10
   } conv_state_type;
endpackage

`default_nettype wire

/* File: logic/sar_adc_conversion_serial_readout.sv */
// digital side of an 18-bit sar adc: conversion timing and serial readout
`default_nettype none

module sar_adc_conversion_serial_readout
(
   // clock and reset
   input  wire  logic        clock,
   input  wire  logic        rst_b,
   // pins from the host
   input  wire  logic        conversionStart,
   input  wire  logic        serialClock,
   input  wire  logic        serialInModeSelect,
   // sample value from the analog front end, offset binary
   input  wire  logic [17:0] sampleCode,
   // serial output pin
   output var   logic        serialResultOut,
   output logic              serialResultOutEn,
   // status
   output var   logic        convBusy,
   output var   logic        daisyMode
);

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   logic rstSync1;
   logic rstSyncB;

   // release through two flops, assertion stays asynchronous
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstSync1 <= 1'b0;
         rstSyncB <= 1'b0;
      end
      else
      begin
         rstSync1 <= 1'b1;
         rstSyncB <= rstSync1;
      end
   end

   // -----------------------------------------------------------------
   // pin synchronisers and edge detection
   // -----------------------------------------------------------------
   logic [2:0] cnvMeta;
   logic [2:0] sclkMeta;
   logic [1:0] sdiMeta;
   logic       cnvSync;
   logic       cnvPrev;
   logic       sclkSync;
   logic       sclkPrev;
   logic       sdiSync;
   logic       cnvRise;
   logic       sclkFall;

   // stage 0 feeds only stage 1; edges read stages 1 and 2
   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         cnvMeta  <= 3'h0;
         sclkMeta <= 3'h0;
         sdiMeta  <= 2'h0;
      end
      else
      begin
         cnvMeta  <= {cnvMeta[1:0], conversionStart};
         sclkMeta <= {sclkMeta[1:0], serialClock};
         sdiMeta  <= {sdiMeta[0], serialInModeSelect};
      end
   end

   assign cnvSync  = cnvMeta[1];
   assign cnvPrev  = cnvMeta[2];
   assign sclkSync = sclkMeta[1];
   assign sclkPrev = sclkMeta[2];
   assign sdiSync  = sdiMeta[1];
   assign cnvRise  = cnvSync & ~cnvPrev;
   assign sclkFall = sclkPrev & ~sclkSync;

   // -----------------------------------------------------------------
   // conversion sequencer
   // -----------------------------------------------------------------
   sar_adc_pkg::conv_state_type state;
   logic [4:0]  convCount;
   logic [17:0] heldSample;
   logic        convDone;

   // internal clock times the conversion, serial clock plays no part
   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         state      <= sar_adc_pkg::IDLE_STATE;
         convCount  <= 5'h00;
         heldSample <= sar_adc_pkg::RESULT_RESET;
      end
      else
      begin
         case (state)
            sar_adc_pkg::IDLE_STATE:
            begin
               if (cnvRise)                                   // [RQ1]
               begin
                  heldSample <= sampleCode;                   // [RQ14]
                  convCount  <= sar_adc_pkg::CONV_COUNT;      // [RQ8]
                  state      <= sar_adc_pkg::CONVERT_STATE;
               end
            end
            sar_adc_pkg::CONVERT_STATE:
            begin
               convCount <= convCount - 5'h01;
               if (convCount == 5'h01)
                  state <= sar_adc_pkg::IDLE_STATE;
            end
            default:
               state <= sar_adc_pkg::IDLE_STATE;
         endcase
      end
   end

   assign convDone = (state == sar_adc_pkg::CONVERT_STATE) && (convCount == 5'h01);
   assign convBusy = (state == sar_adc_pkg::CONVERT_STATE);

   // -----------------------------------------------------------------
   // mode and busy-indicator arming
   // -----------------------------------------------------------------
   logic daisyBusyEnable;
   logic busyArmed;

   // mode and daisy busy option caught at the start edge
   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         daisyMode       <= 1'b0;
         daisyBusyEnable <= 1'b0;
      end
      else if (cnvRise)
      begin
         daisyMode       <= ~sdiSync;                         // [RQ1] [RQ2]
         daisyBusyEnable <= sclkSync;                         // [RQ13]
      end
   end

   // -----------------------------------------------------------------
   // output shift register
   // -----------------------------------------------------------------
   logic [17:0] shiftReg;
   logic        selected;
   logic        csLow;

   assign csLow    = ~sdiSync | ~cnvSync;
   // daisy chain is selected while conversion-start is low
   assign selected = daisyMode ? ~cnvSync : csLow;            // [RQ6]

   // result loads msb first; a busy bit, when armed, precedes it
   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         shiftReg        <= sar_adc_pkg::RESULT_RESET;
         serialResultOut <= 1'b0;
         busyArmed       <= 1'b0;
      end
      else if (convDone)
      begin
         shiftReg  <= heldSample;
         busyArmed <= daisyMode ? daisyBusyEnable : csLow;     // [RQ4] [RQ13]
         // busy bit high marks end, else msb shows straight away
         serialResultOut <= (daisyMode ? daisyBusyEnable : csLow) ? 1'b1 : heldSample[17]; // [RQ12] [RQ15]
      end
      else if (sclkFall && selected && !convBusy)             // [RQ5] [RQ6]
      begin
         if (busyArmed)
         begin
            busyArmed       <= 1'b0;                          // [RQ12]
            serialResultOut <= shiftReg[17];
         end
         else
         begin
            shiftReg        <= {shiftReg[16:0], daisyMode ? sdiSync : 1'b0}; // [RQ7]
            serialResultOut <= shiftReg[16];                  // [RQ15]
         end
      end
   end

   // driver enable: cs mode on either low, daisy while selected
   assign serialResultOutEn = daisyMode ? ~cnvSync : csLow;   // [RQ3] [RQ15]

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   AST_CONV_LENGTH: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ8]
      (cnvRise && state == sar_adc_pkg::IDLE_STATE) |=> convBusy [*8] ##1 convBusy [*7] ##1 !convBusy)
      else $error("conversion length wrong");
   AST_MODE_LATCH: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ2]
      cnvRise |=> daisyMode == !$past(sdiSync))
      else $error("mode not latched from serial input");
   AST_CS_ENABLE: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ3]
      !daisyMode |-> serialResultOutEn == (!sdiSync || !cnvSync))
      else $error("chip-select enable wrong");
   AST_NO_SHIFT_UNSEL: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ6]
      (!selected && !convDone) |=> $stable(shiftReg) && $stable(serialResultOut))
      else $error("shifted while unselected");
   AST_FALL_ONLY: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ5]
      (!sclkFall && !convDone) |=> $stable(serialResultOut))
      else $error("output changed off a falling edge");
   AST_CS_BUSY_ARM: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ4]
      (convDone && !daisyMode) |=> busyArmed == $past(csLow))
      else $error("busy arming wrong");
   AST_DAISY_BUSY: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ13]
      (convDone && daisyMode) |=> busyArmed == $past(daisyBusyEnable))
      else $error("daisy busy option wrong");
   AST_BUSY_BIT: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ12]
      (convDone && (daisyMode ? daisyBusyEnable : csLow)) |=> serialResultOut)
      else $error("busy bit not shown");
   AST_MSB_FIRST: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ15]
      (convDone && !(daisyMode ? daisyBusyEnable : csLow)) |=> serialResultOut == shiftReg[17])
      else $error("msb not first");
   AST_DAISY_IN: assert property (@(posedge clock) disable iff (!rstSyncB) // [RQ7]
      (sclkFall && selected && daisyMode && !busyArmed && !convBusy && !convDone)
      |=> shiftReg[0] == $past(sdiSync))
      else $error("daisy input not shifted in");

   COV_CS: cover property (@(posedge clock) disable iff (!rstSyncB) convDone && !daisyMode);
   COV_DAISY: cover property (@(posedge clock) disable iff (!rstSyncB) convDone && daisyMode);
   COV_BUSY_FLUSH: cover property (@(posedge clock) disable iff (!rstSyncB)
      busyArmed && sclkFall && selected && !convBusy);

endmodule // sar_adc_conversion_serial_readout

`default_nettype wire

/* File: tb/adc_host_model.sv */
// host controller model: drives the converter pins and reads the serial result
`default_nettype none

module adc_host_model
(
   // clock of the bench
   input  wire logic clock,
   // pins towards the converter
   output var  logic conversionStart,
   output var  logic serialClock,
   output var  logic serialInModeSelect,
   input  wire logic sdoLine
);
   timeunit 1ns;
   timeprecision 1ns;

   // pins quiet and low from time zero
   initial
   begin
      conversionStart = 1'b0;
      serialClock = 1'b0;
      serialInModeSelect = 1'b0;
   end

   // one conversion; serial clock stands still outside frames apart from the daisy busy option level and idle pulses
   task automatic convert(input logic daisy, opt, input int idle);
      @(negedge clock);
      conversionStart <= 1'b0;
      serialInModeSelect <= !daisy;
      serialClock <= daisy & opt;
      repeat (8) @(negedge clock);
      conversionStart <= 1'b1;
      repeat (6) @(negedge clock);
      serialClock <= 1'b0;
      conversionStart <= !(!daisy & opt); // low at conversion end arms busy bit
      repeat (20) @(negedge clock);
      // pulses while unselected must be ignored
      repeat (idle)
      begin
         serialClock <= 1'b1;
         repeat (4) @(negedge clock);
         serialClock <= 1'b0;
         repeat (4) @(negedge clock);
      end
   endtask

   // select, then clock n bits in at 800 ns per bit; chain bits feed the serial input
   task automatic readBits(input int n, input logic [17:0] chain, output logic [39:0] word);
      word = 40'h0;
      conversionStart <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         if (i < 18)
            serialInModeSelect <= chain[17 - i];
         serialClock <= 1'b1;
         repeat (4) @(negedge clock);
         word = {word[38:0], sdoLine}; // busy bit comes first, then flushed
         serialClock <= 1'b0;
         repeat (4) @(negedge clock);
      end
   endtask
endmodule // adc_host_model

`default_nettype wire

/* File: tb/sar_adc_conversion_serial_readout_tb.sv */
// self-checking bench for the sar adc conversion and serial readout block
`default_nettype none

module sar_adc_conversion_serial_readout_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [17:0] sampleCode = 18'h00000;
   logic        conversionStart;
   logic        serialClock;
   logic        serialInModeSelect;
   logic        serialResultOut;
   logic        serialResultOutEn;
   logic        convBusy;
   logic        daisyMode;
   logic        lastOut = 1'b0;
   wire logic   sdoLine;
   int          fails = 0;
   int          checked = 0;
   int          busyLen = 0;
   logic [31:0] seed = 32'hD8E97383;

   // released line toggles every cycle, so a stale value never reads as data
   assign sdoLine = serialResultOutEn ? serialResultOut : ~lastOut;
   always @(posedge clock) lastOut <= sdoLine;

   initial
   begin
      forever #50 clock = ~clock;
   end

   sar_adc_conversion_serial_readout u_dut
   (
      .clock              (clock),
      .rst_b              (rst_b),
      .conversionStart    (conversionStart),
      .serialClock        (serialClock),
      .serialInModeSelect (serialInModeSelect),
      .sampleCode         (sampleCode),
      .serialResultOut    (serialResultOut),
      .serialResultOutEn  (serialResultOutEn),
      .convBusy           (convBusy),
      .daisyMode          (daisyMode)
   );

   adc_host_model u_host
   (
      .clock              (clock),
      .conversionStart    (conversionStart),
      .serialClock        (serialClock),
      .serialInModeSelect (serialInModeSelect),
      .sdoLine            (sdoLine)
   );

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // expected stream right aligned: busy bit, own word msb first, chained word
   function automatic logic [39:0] expectWord(input logic daisy, opt, input logic [17:0] code, chain);
      if (opt)
         return {21'h0, 1'b1, code};
      if (daisy)
         return {4'h0, code, chain};
      return {22'h0, code};
   endfunction

   task automatic check(input logic [39:0] seen, expected);
      checked++;
      if (seen !== expected)
      begin
         fails++;
         $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, expected);
      end
   endtask

   // each busy period must last the internal conversion time, counted at its end
   always @(negedge clock)
   begin
      if (convBusy)
         busyLen <= busyLen + 1;
      else if (busyLen != 0)
      begin
         check(40'(busyLen), 40'(sar_adc_pkg::CONV_CYCLES));
         busyLen <= 0;
      end
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // tests: four corner cases, then random mode, busy option and codes
   // ------------------------------------------------------------------
   initial
   begin : main
      logic [39:0] word;
      logic [17:0] chain;
      logic        daisy;
      logic        opt;
      int          n;
      repeat (12) @(negedge clock);
      rst_b = 1'b1;
      repeat (5) @(negedge clock);
      for (int t = 0; t < 12; t++)
      begin
         seed = xorshift(seed);
         daisy = (t < 4) ? t[1] : seed[0];
         opt = (t < 4) ? t[0] : seed[1];
         chain = seed[31:14];
         sampleCode = (t == 0) ? sar_adc_pkg::MIDSCALE_CODE : (t == 1) ? 18'h3FFFF : (t == 2) ? 18'h00000 : seed[17:0];
         u_host.convert(daisy, opt, (daisy | opt) ? 0 : 3);
         check({39'h0, daisyMode}, {39'h0, daisy});
         if (!daisy)
            check({39'h0, serialResultOutEn}, {39'h0, opt});
         n = opt ? 19 : daisy ? 36 : 18;
         u_host.readBits(n, daisy ? chain : 18'h3FFFF, word);
         check(word, expectWord(daisy, opt, sampleCode, chain));
         $display("case %0d done: daisy %0d busy option %0d", t, daisy, opt);
      end
      print_verdict();
   end

   // twelve cases need under 0.5 ms; twice that means a hang
   initial
   begin
      #1000000;
      fails++;
      print_verdict();
   end
endmodule // sar_adc_conversion_serial_readout_tb

`default_nettype wire
